//--- pkg/ubh_consts.svh
// Offsets, field positions and masks for the break-unit host controller.
// Assumes the breakpoint unit decodes a byte offset on its own register port.
`ifndef UBH_CONSTS_SVH
`define UBH_CONSTS_SVH

// Staging slots, also the index into the host's own register window
`define UBH_IDX_COND0    4'h0
`define UBH_IDX_COND1    4'h1
`define UBH_IDX_ADDR0    4'h2
`define UBH_IDX_ADDR1    4'h3
`define UBH_IDX_AMASK0   4'h4
`define UBH_IDX_AMASK1   4'h5
`define UBH_IDX_DATA     4'h6
`define UBH_IDX_DMASK    4'h7
`define UBH_IDX_COUNT    4'h8
`define UBH_IDX_ACTION0  4'h9
`define UBH_IDX_ACTION1  4'ha
`define UBH_IDX_FKEEP    4'hb
`define UBH_NSLOT        12

// Host register byte offsets beyond the staging slots
`define UBH_OFF_CMD      8'h30
`define UBH_OFF_STATUS   8'h34
`define UBH_OFF_FLAGS    8'h38
`define UBH_OFF_RDBACK   8'h3c

// Command bits
`define UBH_CMD_PROG0    0
`define UBH_CMD_PROG1    1
`define UBH_CMD_CLEAR    2
`define UBH_CMD_RDFLAG   3

// Status bits
`define UBH_ST_BUSY      0
`define UBH_ST_ERR_LSB   1
`define UBH_ST_ERR_UNSET 2
`define UBH_ST_DONE      3
`define UBH_ST_ERR_BUSY  4

// Device register byte offsets on the unit's own port
`define UBH_DEV_COND0    8'h00
`define UBH_DEV_COND1    8'h04
`define UBH_DEV_ADDR0    8'h08
`define UBH_DEV_ADDR1    8'h0c
`define UBH_DEV_AMASK0   8'h10
`define UBH_DEV_AMASK1   8'h14
`define UBH_DEV_DATA     8'h18
`define UBH_DEV_DMASK    8'h1c
`define UBH_DEV_COUNT    8'h20
`define UBH_DEV_ACTION0  8'h24
`define UBH_DEV_ACTION1  8'h28
`define UBH_DEV_FLAG     8'h2c

// Match condition register fields
`define UBH_COND_ENABLE  0
`define UBH_COND_FETCH   1

// Execution count is 12 bits wide
`define UBH_COUNT_MASK   32'h0000_0fff
`define UBH_FLAG_MASK    32'h0000_0003
`define UBH_ZERO32       32'h0000_0000

`endif

//--- pkg/ubh_pkg.sv
// Types for the break-unit host controller.
// Assumes ubh_consts.svh for the numbers.
package ubh_pkg;

  typedef enum logic [2:0] {
    UBH_IDLE  = 3'b001,
    UBH_ISSUE = 3'b010,
    UBH_WAIT  = 3'b100
  } ubh_state_t;

  typedef enum logic [1:0] {
    UBH_OP_PROG0 = 2'h0,
    UBH_OP_PROG1 = 2'h1,
    UBH_OP_CLEAR = 2'h2,
    UBH_OP_RFLAG = 2'h3
  } ubh_op_t;

  // Write with enable forced low, plain write, write with enable, read back
  typedef enum logic [1:0] {
    UBH_K_WR_OFF = 2'h0,
    UBH_K_WR     = 2'h1,
    UBH_K_WR_ON  = 2'h2,
    UBH_K_RD     = 2'h3
  } ubh_kind_t;

  typedef struct packed {
    logic        last;
    ubh_kind_t   kind;
    logic [3:0]  idx;
  } ubh_step_t;

  typedef struct packed {
    ubh_state_t       state;
    ubh_op_t          op;
    logic [3:0]       step;
    logic [11:0][31:0] stage;
    logic [11:0]      staged;
    logic             a_wr;
    logic             a_valid;
    logic [7:0]       a_addr;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic [4:0]       status;
    logic [31:0]      flags;
    logic [31:0]      rdback;
    logic             req;
    logic             req_wr;
    logic [7:0]       req_addr;
    logic [31:0]      req_wdata;
  } ubh_top_s_t;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        done;
    logic [31:0] rdata;
  } ubh_port_s_t;

endpackage : ubh_pkg

//--- design/ubh_dev_port.sv
// Single-transaction master on the breakpoint unit's register port.
// Assumes the unit raises dev_ack for one or more cycles while dev_sel is high.
`timescale 1ns/1ps
`include "ubh_consts.svh"

module ubh_dev_port (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        req,
  input  wire logic        req_wr,
  input  wire logic [7:0]  req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             done,
  output logic [31:0]      rdata,
  output logic             dev_sel,
  output logic             dev_wr,
  output logic [7:0]       dev_addr,
  output logic [31:0]      dev_wdata,
  input  wire logic [31:0] dev_rdata,
  input  wire logic        dev_ack
);
  import ubh_pkg::*;

  ubh_port_s_t s_ff;
  ubh_port_s_t nxt_s;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    if (s_ff.sel) begin
      // Address and data stay frozen until the unit acknowledges
      if (dev_ack) begin
        nxt_s.sel   = 1'b0;
        nxt_s.done  = 1'b1;
        nxt_s.rdata = s_ff.wr ? s_ff.rdata : dev_rdata;
      end
    end else if (req) begin
      nxt_s.sel   = 1'b1;
      nxt_s.wr    = req_wr;
      nxt_s.addr  = req_addr;
      nxt_s.wdata = req_wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done      = s_ff.done;
  assign rdata     = s_ff.rdata;
  assign dev_sel   = s_ff.sel;
  assign dev_wr    = s_ff.wr;
  assign dev_addr  = s_ff.addr;
  assign dev_wdata = s_ff.wdata;

endmodule : ubh_dev_port

//--- design/ubh_host.sv
// Host controller that programs a two-channel breakpoint unit and services its flags.
// Assumes an AHB-Lite master with a single slave, and the unit's register port
// served by ubh_dev_port.
`timescale 1ns/1ps
`include "ubh_consts.svh"

// How it works
// - Software avoids data match on dataless ops
// - Condition, address, mask written per channel
// - ASID enable and value sent in condition
// - Channel 1 data and mask written
// - Execution count written for channel 1
// - Sequence fields sent in condition word
// - Action register written per channel
// - Enable written last, then condition read back
// - Refuse enable before all registers staged
// - CPU takes break only when unmasked
// - Flags cleared only by writing zero
// - Software clears first channel flag
// - Fetch break needs request enable, timing
// - Refuse fetch condition with odd address
// - No pre-execution break on return slot
module ubh_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             dev_sel,
  output logic             dev_wr,
  output logic [7:0]       dev_addr,
  output logic [31:0]      dev_wdata,
  input  wire logic [31:0] dev_rdata,
  input  wire logic        dev_ack
);
  import ubh_pkg::*;

  ubh_top_s_t  s_ff;
  ubh_top_s_t  nxt_s;
  logic        port_done;
  logic [31:0] port_rdata;
  ubh_step_t   cur;

  // Programming order: enable off first, enable on last, then read back
  function automatic ubh_step_t seq_step(input ubh_op_t op, input logic [3:0] step);
    ubh_step_t e;
    e = '{last: 1'b1, kind: UBH_K_RD, idx: `UBH_IDX_FKEEP};
    case (op)
      UBH_OP_PROG0: begin
        case (step)
          4'h0:    e = '{1'b0, UBH_K_WR_OFF, `UBH_IDX_COND0};
          4'h1:    e = '{1'b0, UBH_K_WR,     `UBH_IDX_ADDR0};
          4'h2:    e = '{1'b0, UBH_K_WR,     `UBH_IDX_AMASK0};
          4'h3:    e = '{1'b0, UBH_K_WR,     `UBH_IDX_ACTION0};
          4'h4:    e = '{1'b0, UBH_K_WR_ON,  `UBH_IDX_COND0};
          default: e = '{1'b1, UBH_K_RD,     `UBH_IDX_COND0};
        endcase
      end
      UBH_OP_PROG1: begin
        case (step)
          4'h0:    e = '{1'b0, UBH_K_WR_OFF, `UBH_IDX_COND1};
          4'h1:    e = '{1'b0, UBH_K_WR,     `UBH_IDX_ADDR1};
          4'h2:    e = '{1'b0, UBH_K_WR,     `UBH_IDX_AMASK1};
          4'h3:    e = '{1'b0, UBH_K_WR,     `UBH_IDX_DATA};
          4'h4:    e = '{1'b0, UBH_K_WR,     `UBH_IDX_DMASK};
          4'h5:    e = '{1'b0, UBH_K_WR,     `UBH_IDX_COUNT};
          4'h6:    e = '{1'b0, UBH_K_WR,     `UBH_IDX_ACTION1};
          4'h7:    e = '{1'b0, UBH_K_WR_ON,  `UBH_IDX_COND1};
          default: e = '{1'b1, UBH_K_RD,     `UBH_IDX_COND1};
        endcase
      end
      UBH_OP_CLEAR: e = '{1'b1, UBH_K_WR, `UBH_IDX_FKEEP};
      default:      e = '{1'b1, UBH_K_RD, `UBH_IDX_FKEEP};
    endcase
    return e;
  endfunction : seq_step

  function automatic logic [7:0] dev_off(input logic [3:0] idx);
    logic [7:0] o;
    o = `UBH_DEV_FLAG;
    case (idx)
      `UBH_IDX_COND0:   o = `UBH_DEV_COND0;
      `UBH_IDX_COND1:   o = `UBH_DEV_COND1;
      `UBH_IDX_ADDR0:   o = `UBH_DEV_ADDR0;
      `UBH_IDX_ADDR1:   o = `UBH_DEV_ADDR1;
      `UBH_IDX_AMASK0:  o = `UBH_DEV_AMASK0;
      `UBH_IDX_AMASK1:  o = `UBH_DEV_AMASK1;
      `UBH_IDX_DATA:    o = `UBH_DEV_DATA;
      `UBH_IDX_DMASK:   o = `UBH_DEV_DMASK;
      `UBH_IDX_COUNT:   o = `UBH_DEV_COUNT;
      `UBH_IDX_ACTION0: o = `UBH_DEV_ACTION0;
      `UBH_IDX_ACTION1: o = `UBH_DEV_ACTION1;
      default:          o = `UBH_DEV_FLAG;
    endcase
    return o;
  endfunction : dev_off

  // Slots that must be staged since reset before a channel may be enabled
  localparam logic [11:0] NEED0 = 12'h215;
  localparam logic [11:0] NEED1 = 12'h5ea;

  // Slots a program command sends; channel 0 wins when both bits are set
  function automatic logic [11:0] need_of(input logic [31:0] c);
    logic [11:0] m;
    m = NEED1;
    if (c[`UBH_CMD_PROG0]) begin
      m = NEED0;
    end
    return m;
  endfunction : need_of

  // Offsets below the command register select a staging slot
  function automatic logic in_slots(input logic [7:0] off);
    return off < 8'(`UBH_NSLOT * 4);
  endfunction : in_slots

  // Command decode in priority order: program ch0, program ch1, clear, read flags
  function automatic ubh_op_t cmd_op(input logic [31:0] c);
    ubh_op_t o;
    o = UBH_OP_RFLAG;
    if (c[`UBH_CMD_PROG0]) begin
      o = UBH_OP_PROG0;
    end else if (c[`UBH_CMD_PROG1]) begin
      o = UBH_OP_PROG1;
    end else if (c[`UBH_CMD_CLEAR]) begin
      o = UBH_OP_CLEAR;
    end
    return o;
  endfunction : cmd_op

  // Why a program command is refused: bit1 unstaged slot, bit0 odd fetch address.
  // An unintended break costs more than a refused command, so both are checked up front.
  function automatic logic [1:0] prog_refusal(input logic [31:0] c,
                                              input logic [11:0] staged,
                                              input logic [31:0] cond,
                                              input logic [31:0] addr);
    logic [1:0] e;
    e = 2'b00;
    if ((staged & need_of(c)) != need_of(c)) begin
      e = 2'b10;
    end else if (cond[`UBH_COND_FETCH] && addr[0]) begin
      e = 2'b01;
    end
    return e;
  endfunction : prog_refusal

  // The execution count is twelve bits wide; upper bits of the slot always read zero
  function automatic logic [31:0] slot_word(input logic [3:0]  idx,
                                            input logic [31:0] w);
    logic [31:0] r;
    r = w;
    if (idx == `UBH_IDX_COUNT) begin
      r = w & `UBH_COUNT_MASK;
    end
    return r;
  endfunction : slot_word

  // Host register read mux; unmapped offsets and the command register read as zero
  function automatic logic [31:0] host_rd(input logic [7:0]  off,
                                          input logic [4:0]  st,
                                          input ubh_top_s_t  cs);
    logic [31:0] r;
    r = `UBH_ZERO32;
    if (in_slots(off)) begin
      r = cs.stage[off[5:2]];
    end else begin
      case (off)
        `UBH_OFF_STATUS: r = {27'h0, st};
        `UBH_OFF_FLAGS:  r = cs.flags;
        `UBH_OFF_RDBACK: r = cs.rdback;
        default:         r = `UBH_ZERO32;
      endcase
    end
    return r;
  endfunction : host_rd

  // Word sent to the unit for one step. Condition words pass ASID, data, count and
  // sequence fields as staged; only the enable bit is forced.
  function automatic logic [31:0] issue_word(input ubh_step_t   e,
                                             input logic [31:0] w);
    logic [31:0] r;
    r = w;
    if (e.kind == UBH_K_WR_OFF) begin
      r[`UBH_COND_ENABLE] = 1'b0;
    end else if (e.kind == UBH_K_WR_ON) begin
      r[`UBH_COND_ENABLE] = 1'b1;
    end
    if (e.idx == `UBH_IDX_FKEEP) begin
      r = r & `UBH_FLAG_MASK;
    end
    return r;
  endfunction : issue_word

  assign cur = seq_step(s_ff.op, s_ff.step);

  always_comb begin
    logic [31:0] word;
    logic [31:0] rd;
    logic [3:0]  sidx;
    logic        wr_now;
    logic [31:0] cmd;
    logic [31:0] cond;
    logic [31:0] addr;
    logic [1:0]  refuse;
    word   = `UBH_ZERO32;
    rd     = `UBH_ZERO32;
    sidx   = s_ff.a_addr[5:2];
    wr_now = s_ff.a_valid && s_ff.a_wr;
    cmd    = hwdata;
    cond   = `UBH_ZERO32;
    addr   = `UBH_ZERO32;
    refuse = 2'b00;
    nxt_s  = s_ff;
    nxt_s.req = 1'b0;

    // Data phase of a write captured one cycle earlier
    if (wr_now) begin
      if (in_slots(s_ff.a_addr)) begin
        nxt_s.stage[sidx]  = slot_word(sidx, hwdata);
        nxt_s.staged[sidx] = 1'b1;
      end else if (s_ff.a_addr == `UBH_OFF_CMD) begin
        if (s_ff.state != UBH_IDLE) begin
          nxt_s.status[`UBH_ST_ERR_BUSY] = 1'b1;
        end else if (cmd[`UBH_CMD_PROG0] || cmd[`UBH_CMD_PROG1]) begin
          nxt_s.status[`UBH_ST_ERR_LSB]   = 1'b0;
          nxt_s.status[`UBH_ST_ERR_UNSET] = 1'b0;
          nxt_s.status[`UBH_ST_ERR_BUSY]  = 1'b0;
          nxt_s.status[`UBH_ST_DONE]      = 1'b0;
          if (cmd[`UBH_CMD_PROG0]) begin
            cond = s_ff.stage[`UBH_IDX_COND0];
            addr = s_ff.stage[`UBH_IDX_ADDR0];
          end else begin
            cond = s_ff.stage[`UBH_IDX_COND1];
            addr = s_ff.stage[`UBH_IDX_ADDR1];
          end
          refuse = prog_refusal(cmd, s_ff.staged, cond, addr);
          nxt_s.status[`UBH_ST_ERR_UNSET] = refuse[1];
          nxt_s.status[`UBH_ST_ERR_LSB]   = refuse[0];
          if (refuse == 2'b00) begin
            nxt_s.op    = cmd_op(cmd);
            nxt_s.step  = 4'h0;
            nxt_s.state = UBH_ISSUE;
          end
        end else if (cmd[`UBH_CMD_CLEAR] || cmd[`UBH_CMD_RDFLAG]) begin
          nxt_s.status[`UBH_ST_DONE] = 1'b0;
          nxt_s.op    = cmd_op(cmd);
          nxt_s.step  = 4'h0;
          nxt_s.state = UBH_ISSUE;
        end
      end
    end

    case (s_ff.state)
      UBH_IDLE: begin
      end
      UBH_ISSUE: begin
        word = issue_word(cur, s_ff.stage[cur.idx]);
        nxt_s.req       = 1'b1;
        nxt_s.req_wr    = (cur.kind != UBH_K_RD);
        nxt_s.req_addr  = dev_off(cur.idx);
        nxt_s.req_wdata = word;
        nxt_s.state     = UBH_WAIT;
      end
      UBH_WAIT: begin
        if (port_done) begin
          if (cur.kind == UBH_K_RD) begin
            if (cur.idx == `UBH_IDX_FKEEP) begin
              nxt_s.flags = port_rdata & `UBH_FLAG_MASK;
            end else begin
              nxt_s.rdback = port_rdata;
            end
          end
          if (cur.last) begin
            nxt_s.state                = UBH_IDLE;
            nxt_s.status[`UBH_ST_DONE] = 1'b1;
          end else begin
            nxt_s.step  = s_ff.step + 4'h1;
            nxt_s.state = UBH_ISSUE;
          end
        end
      end
      default: begin
        nxt_s.state = UBH_IDLE;
      end
    endcase
    nxt_s.status[`UBH_ST_BUSY] = (nxt_s.state != UBH_IDLE);

    // Address phase; read data is prepared now so it stands in the data phase
    nxt_s.a_valid = hsel && hready && htrans[1];
    if (hsel && hready) begin
      nxt_s.a_wr   = hwrite;
      nxt_s.a_addr = haddr[7:0] & 8'hfc;
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      rd = host_rd(haddr[7:0] & 8'hfc, nxt_s.status, s_ff);
      nxt_s.hrdata = rd;
    end
    nxt_s.hreadyout = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff           <= '0;
      s_ff.state     <= UBH_IDLE;
      s_ff.op        <= UBH_OP_PROG0;
      s_ff.hreadyout <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ubh_dev_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .req       (s_ff.req),
    .req_wr    (s_ff.req_wr),
    .req_addr  (s_ff.req_addr),
    .req_wdata (s_ff.req_wdata),
    .done      (port_done),
    .rdata     (port_rdata),
    .dev_sel   (dev_sel),
    .dev_wr    (dev_wr),
    .dev_addr  (dev_addr),
    .dev_wdata (dev_wdata),
    .dev_rdata (dev_rdata),
    .dev_ack   (dev_ack)
  );

  assign hreadyout = s_ff.hreadyout;
  assign hrdata    = s_ff.hrdata;
  assign hresp     = 1'b0;

endmodule : ubh_host

//--- bench/ubh_dev_model.sv
// Behavioural breakpoint unit register port for the host bench.
// Assumes the host holds dev_sel and its qualifiers until it samples dev_ack.
`timescale 1ns/1ps
`include "ubh_consts.svh"
module ubh_dev_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        dev_sel,
  input  wire logic        dev_wr,
  input  wire logic [7:0]  dev_addr,
  input  wire logic [31:0] dev_wdata,
  output logic [31:0]      dev_rdata,
  output logic             dev_ack,
  input  wire logic [1:0]  hit,
  input  wire logic [3:0]  ack_delay
);
  logic [11:0][31:0] regs_ff;
  logic [1:0]        flags_ff;
  logic [3:0]        wait_ff;
  logic [31:0]       last_ff;
  logic              is_flag;
  assign is_flag = dev_addr == `UBH_DEV_FLAG;
  assign dev_ack = dev_sel && wait_ff == ack_delay;
  // Outside an answer the lines show junk, never the last value
  assign dev_rdata = !dev_ack ? ~last_ff :
                     is_flag ? {30'h0, flags_ff} : regs_ff[dev_addr[5:2]];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      regs_ff  <= '1; // Stand-in for the undefined state after reset
      flags_ff <= 2'h0;
      wait_ff  <= 4'h0;
      last_ff  <= 32'h0;
    end else begin
      wait_ff <= (dev_sel && !dev_ack) ? wait_ff + 4'h1 : 4'h0;
      if (dev_ack) last_ff <= dev_rdata;
      if (dev_ack && dev_wr && !is_flag)
        regs_ff[dev_addr[5:2]] <= (dev_addr == `UBH_DEV_COUNT) ?
                                  (dev_wdata & `UBH_COUNT_MASK) : dev_wdata;
      // A hit wins over a clearing store in the same cycle
      if (dev_ack && dev_wr && is_flag)
        flags_ff <= (flags_ff & dev_wdata[1:0]) | hit;
      else
        flags_ff <= flags_ff | hit;
    end
  end
endmodule : ubh_dev_model

//--- bench/ubh_host_assertions.sv
// Port checker for the break-unit host controller.
// Assumes it is bound to ubh_host and sees only its ports.
`timescale 1ns/1ps
`include "ubh_consts.svh"
module ubh_host_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        dev_sel,
  input wire logic        dev_wr,
  input wire logic [7:0]  dev_addr,
  input wire logic [31:0] dev_wdata,
  input wire logic [31:0] dev_rdata,
  input wire logic        dev_ack
);
  logic cmd_seen_ff;
  logic lsb0_ff;
  logic wr_ack;
  assign wr_ack = dev_sel && dev_ack && dev_wr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_seen_ff <= 1'b0;
      lsb0_ff     <= 1'b0;
    end else begin
      if (hsel && hready && htrans[1] && hwrite && haddr[7:0] == `UBH_OFF_CMD)
        cmd_seen_ff <= 1'b1;
      if (wr_ack && dev_addr == `UBH_DEV_ADDR0) lsb0_ff <= dev_wdata[0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
  chk_sel_hold: assert property (dev_sel && !dev_ack |=> dev_sel && $stable(dev_addr)
    && $stable(dev_wr) && $stable(dev_wdata)) else $error("device request changed early");
  chk_sel_gap: assert property (dev_sel && dev_ack |=> !dev_sel [*2])
    else $error("device select not released");
  chk_sel_cause: assert property ($rose(dev_sel) |-> cmd_seen_ff)
    else $error("device access without command");
  chk_rdback0: assert property (wr_ack && dev_addr == `UBH_DEV_COND0 && dev_wdata[0]
    |=> ##[1:8] dev_sel && !dev_wr && dev_addr == `UBH_DEV_COND0)
    else $error("channel 0 condition not read back");
  chk_rdback1: assert property (wr_ack && dev_addr == `UBH_DEV_COND1 && dev_wdata[0]
    |=> ##[1:8] dev_sel && !dev_wr && dev_addr == `UBH_DEV_COND1)
    else $error("channel 1 condition not read back");
  chk_fetch_lsb: assert property (wr_ack && dev_addr == `UBH_DEV_COND0
    && dev_wdata[1:0] == 2'h3 |-> !lsb0_ff) else $error("fetch enabled on odd address");
  chk_flag_bits: assert property (dev_sel && dev_wr && dev_addr == `UBH_DEV_FLAG
    |-> dev_wdata[31:2] == 30'h0) else $error("flag store touches reserved bits");
  chk_hrdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite)
    |=> $stable(hrdata)) else $error("hrdata changed without read");
endmodule : ubh_host_assertions

bind ubh_host ubh_host_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .dev_sel(dev_sel), .dev_wr(dev_wr), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
  .dev_rdata(dev_rdata), .dev_ack(dev_ack));

//--- bench/ubh_host_test.sv
// Self-checking bench for ubh_host driving a behavioural breakpoint unit.
// Assumes one AHB-Lite slave, so hready is the host's own hreadyout.
`timescale 1ns/1ps
`include "ubh_consts.svh"
module ubh_host_test;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, dev_sel, dev_wr, dev_ack;
  logic [1:0]  htrans, hit;
  logic [2:0]  hsize;
  logic [3:0]  ack_delay;
  logic [7:0]  dev_addr;
  logic [31:0] haddr, hwdata, hrdata, dev_wdata, dev_rdata, q;
  logic [31:0] v [12];
  int          num_errors, total_checks;

  ubh_host uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .dev_sel(dev_sel), .dev_wr(dev_wr), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack));
  ubh_dev_model dev (.hclk(hclk), .hresetn(hresetn), .dev_sel(dev_sel), .dev_wr(dev_wr),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack),
    .hit(hit), .ack_delay(ack_delay));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One single transfer; q takes the read data at the data-phase edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) begin
      num_errors++;
      stop_test();
    end
  endtask : ahb

  task automatic settle;
    int n;
    n = 0;
    do begin
      ahb(1'b0, `UBH_OFF_STATUS, 32'h0);
      n++;
    end while (q[`UBH_ST_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) begin
      num_errors++;
      stop_test();
    end
  endtask : settle

  task automatic run(input logic [31:0] cmd);
    ahb(1'b1, `UBH_OFF_CMD, cmd);
    settle();
  endtask : run

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, hit, ack_delay} = '0;
    hsize = 3'b010;
    num_errors = 0;
    total_checks = 0;
    v = '{32'h0055_0103, 32'h0030_0001, 32'h0000_1001, 32'h2000_0007, 32'h0000_000f,
          32'h0, 32'hcafe_f00d, 32'h0000_ffff, 32'h0000_1abc, 32'h1, 32'h2, 32'h2};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    run(32'h1);
    check(q & 32'h7, 32'h4);
    for (int i = 0; i < 12; i++) ahb(1'b1, {2'b00, i[3:0], 2'b00}, v[i]);
    run(32'h1);
    check(q & 32'h7, 32'h2);
    check(dev.regs_ff[2], 32'hffff_ffff);
    v[2] = 32'h0000_1000;
    ahb(1'b1, 8'h08, v[2]);
    ack_delay <= 4'h5;
    run(32'h1);
    check(q & 32'h1f, 32'h08);
    ack_delay <= 4'h0;
    run(32'h2);
    v[8] = v[8] & `UBH_COUNT_MASK;
    for (int i = 0; i < 11; i++) check(dev.regs_ff[i], v[i]);
    ahb(1'b0, `UBH_OFF_RDBACK, 32'h0);
    check(q, v[1]);
    hit <= 2'b11;
    @(posedge hclk);
    hit <= 2'b00;
    run(32'h8);
    ahb(1'b0, `UBH_OFF_FLAGS, 32'h0);
    check(q, 32'h3);
    run(32'h4);
    run(32'h8);
    ahb(1'b0, `UBH_OFF_FLAGS, 32'h0);
    check(q, 32'h2);
    ahb(1'b1, 8'h2c, 32'h0);
    ahb(1'b1, `UBH_OFF_CMD, 32'h4);
    ahb(1'b1, `UBH_OFF_CMD, 32'h4);
    ahb(1'b0, `UBH_OFF_STATUS, 32'h0);
    check(q & 32'h11, 32'h11);
    settle();
    run(32'h8);
    ahb(1'b0, `UBH_OFF_FLAGS, 32'h0);
    check(q, 32'h0);
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    ahb(1'b0, 8'h40, 32'h0);
    check(q, 32'h0);
    ahb(1'b0, `UBH_OFF_CMD, 32'h0);
    check(q, 32'h0);
    stop_test();
  end
endmodule : ubh_host_test
